// ===== verilog/btq_consts.svh
// constants shared by both ends of the trace qualifier link
`ifndef BTQ_CONSTS_SVH
`define BTQ_CONSTS_SVH

// access-class field width, positions, reset value and instruction value
`define BTQ_CLASS_W 2
`define BTQ_CLASS_UPPER 1
`define BTQ_CLASS_LOWER 0
`define BTQ_CLASS_RST 2'h0
`define BTQ_CLASS_INSTR 1'h1

// load data is the second read after its fetch
`define BTQ_LOAD_LAG 2
`define BTQ_BURST_WORDS 4

`endif

// ===== verilog/btq_pkg.sv
// types of the trace qualifier end's record output, also used by the bench
package btq_pkg;

  typedef enum logic [1:0] {
    BTQ_KIND_NONE,
    BTQ_KIND_INSTR,
    BTQ_KIND_DATA,
    BTQ_KIND_WRITE
  } btq_kind_e;

endpackage : btq_pkg

// ===== verilog/btq_if.sv
// link between the cpu bus end and the trace qualifier end
`timescale 1ns/1ps
`default_nettype none

interface btq_if;
  logic ale;
  logic [1:0] access_class;
  logic wr_n;
  logic rd_n;
  logic ack_n;
  logic read_word_strobe_n;
  logic [31:0] ad;

  modport cpu (
    output ale,
    output access_class,
    output wr_n,
    output rd_n,
    output ack_n,
    output read_word_strobe_n,
    output ad
  );

  modport qual (
    input ale,
    input access_class,
    input wr_n,
    input rd_n,
    input ack_n,
    input read_word_strobe_n,
    input ad
  );
endinterface : btq_if

`default_nettype wire

// ===== verilog/btq_cpu_end.sv
// cpu bus end: drives one bus cycle per user request
`timescale 1ns/1ps
`default_nettype none
`include "btq_consts.svh"

module btq_cpu_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link
  btq_if.cpu bus,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_burst,
  input wire logic [1:0] req_class,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_data,
  output logic req_ready
);

  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} btq_cst_e;

  btq_cst_e st_r;
  logic write_r;
  logic burst_r;
  logic [31:0] data_r;
  logic [2:0] word_r;
  logic ack_r;

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      bus.ale <= 1'b0;
      bus.access_class <= `BTQ_CLASS_RST;
      bus.wr_n <= 1'b1;
      bus.rd_n <= 1'b1;
      bus.ack_n <= 1'b1;
      bus.read_word_strobe_n <= 1'b1;
      bus.ad <= 32'h0;
      req_ready <= 1'b0;
      write_r <= 1'b0;
      burst_r <= 1'b0;
      data_r <= 32'h0;
      word_r <= 3'h0;
      ack_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          bus.wr_n <= 1'b1;
          bus.rd_n <= 1'b1;
          bus.ack_n <= 1'b1;
          bus.read_word_strobe_n <= 1'b1;
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            bus.ale <= 1'b1;
            bus.ad <= req_addr;
            // class left meaningless on writes
            bus.access_class <= req_write ? 2'h3 : req_class;
            write_r <= req_write;
            burst_r <= req_burst & ~req_write;
            data_r <= req_data;
            word_r <= 3'h0;
            st_r <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          bus.ale <= 1'b0;
          bus.ad <= data_r;
          bus.wr_n <= ~write_r;
          bus.rd_n <= write_r;
          st_r <= ST_DATA;
        end
        ST_DATA: begin
          // alternate strobe high/low, one word each low phase
          ack_r <= ~ack_r;
          if (!ack_r) begin
            bus.read_word_strobe_n <= write_r;
            bus.ack_n <= 1'b0;
            word_r <= word_r + 3'h1;
          end else begin
            bus.read_word_strobe_n <= 1'b1;
            bus.ack_n <= 1'b1;
            if (!burst_r || word_r == 3'(`BTQ_BURST_WORDS)) begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

endmodule : btq_cpu_end

`default_nettype wire

// ===== verilog/btq_qual_end.sv
// trace qualifier end: holds access class, forms capture strobes
`timescale 1ns/1ps
`default_nettype none
`include "btq_consts.svh"

module btq_qual_end (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link
  btq_if.qual bus,
  // trace record out
  output logic cap_valid,
  output btq_pkg::btq_kind_e cap_kind,
  output logic [31:0] cap_addr,
  output logic [31:0] cap_data,
  output logic cap_load_data,
  output logic cacheable_probe,
  output logic instr_or_data_probe,
  output logic [1:0] held_access_class
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // ref_clk stands in for the double-rate clock, both cpu phases seen
  logic [5:0] s1_r;
  logic [5:0] s2_r;
  logic [31:0] ad1_r;
  logic [31:0] ad2_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // idle levels: ale low, strobes high, so no false latch after reset
      s1_r <= 6'h1e;
      s2_r <= 6'h1e;
    end else begin
      s1_r <= {bus.ale, bus.wr_n, bus.rd_n, bus.ack_n,
               bus.read_word_strobe_n, 1'b0};
      s2_r <= s1_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ad1_r <= 32'h0;
      ad2_r <= 32'h0;
    end else begin
      ad1_r <= bus.ad;
      ad2_r <= ad1_r;
    end
  end

  logic [1:0] cls1_r;
  logic [1:0] cls2_r;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cls1_r <= `BTQ_CLASS_RST;
      cls2_r <= `BTQ_CLASS_RST;
    end else begin
      cls1_r <= bus.access_class;
      cls2_r <= cls1_r;
    end
  end

  logic ale_s;
  logic wr_n_s;
  logic rd_n_s;
  logic ack_n_s;
  logic rws_n_s;
  assign ale_s = s2_r[5];
  assign wr_n_s = s2_r[4];
  assign rd_n_s = s2_r[3];
  assign ack_n_s = s2_r[2];
  assign rws_n_s = s2_r[1];

  logic ale_d_r;
  logic wr_n_d_r;
  logic strobe_d_r;
  logic [31:0] addr_r;
  logic [1:0] class_r;

  // ----------------------------------------
  // address and class hold
  // ----------------------------------------
  // last sample while ale is high is the one just before it falls,
  // so the muxed bus gives the address without separate probes
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      addr_r <= 32'h0;
      class_r <= `BTQ_CLASS_RST;
    end else if (ale_s) begin
      addr_r <= ad2_r;
      class_r <= cls2_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ale_d_r <= 1'b0;
      wr_n_d_r <= 1'b1;
      strobe_d_r <= 1'b0;
    end else begin
      ale_d_r <= ale_s;
      wr_n_d_r <= wr_n_s;
      strobe_d_r <= ~ack_n_s | ~rws_n_s;
    end
  end

  // ----------------------------------------
  // class probes, only cacheable_probe qualified by wr_n
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      held_access_class <= `BTQ_CLASS_RST;
      cacheable_probe <= 1'b0;
      instr_or_data_probe <= 1'b0;
    end else begin
      held_access_class <= class_r;
      // class is junk on writes, so gate it with the write strobe
      cacheable_probe <= class_r[`BTQ_CLASS_UPPER] & wr_n_s;
      // lower bit passed as is; only meaningful while the upper bit is set
      instr_or_data_probe <= class_r[`BTQ_CLASS_LOWER];
    end
  end

  // ----------------------------------------
  // capture strobes
  // ----------------------------------------
  // read fires on the rise of the combined level, so each burst word
  // gives one record; no deassert of rd between cycles is assumed
  logic rd_fire;
  logic wr_fire;
  assign rd_fire = ~rd_n_s & (~ack_n_s | ~rws_n_s) & ~strobe_d_r;
  // write data is taken as wr_n rises, the last moment it stands on ad
  assign wr_fire = wr_n_s & ~wr_n_d_r;

  // read counter since last cacheable instruction fetch
  // saturates at three, so a long run of reads never wraps into a
  // false load-data mark
  logic [1:0] since_fetch_r;
  logic fetch_seen_r;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      since_fetch_r <= 2'h0;
      fetch_seen_r <= 1'b0;
    end else if (rd_fire) begin
      if (class_r[`BTQ_CLASS_UPPER] &&
          class_r[`BTQ_CLASS_LOWER] == `BTQ_CLASS_INSTR) begin
        since_fetch_r <= 2'h0;
        fetch_seen_r <= 1'b1;
      end else if (since_fetch_r != 2'h3) begin
        since_fetch_r <= since_fetch_r + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cap_valid <= 1'b0;
      cap_kind <= btq_pkg::BTQ_KIND_NONE;
      cap_addr <= 32'h0;
      cap_data <= 32'h0;
      cap_load_data <= 1'b0;
    end else begin
      cap_valid <= rd_fire | wr_fire;
      cap_load_data <= 1'b0;
      if (wr_fire) begin
        cap_kind <= btq_pkg::BTQ_KIND_WRITE;
        cap_addr <= addr_r;
        cap_data <= ad2_r;
      end else if (rd_fire) begin
        cap_addr <= addr_r;
        cap_data <= ad2_r;
        if (!class_r[`BTQ_CLASS_UPPER]) begin
          cap_kind <= btq_pkg::BTQ_KIND_NONE;
        end else if (class_r[`BTQ_CLASS_LOWER] == `BTQ_CLASS_INSTR) begin
          cap_kind <= btq_pkg::BTQ_KIND_INSTR;
        end else begin
          cap_kind <= btq_pkg::BTQ_KIND_DATA;
        end
        cap_load_data <= fetch_seen_r &&
          (since_fetch_r + 2'h1 == 2'(`BTQ_LOAD_LAG));
      end
    end
  end

endmodule : btq_qual_end

`default_nettype wire

// ===== dv/btq_link_monitor.sv
// assertions on the link between the two ends
`timescale 1ns/1ps
`default_nettype none

module btq_link_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // link
  input wire logic ale,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic ack_n,
  input wire logic read_word_strobe_n
);
  // ----------------------------------------
  // link checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_ale_one_cycle: assert property (ale |=> !ale)
    else $error("latch strobe high two cycles");
  a_ale_no_strobe: assert property (ale |-> rd_n && wr_n)
    else $error("latch strobe overlaps a strobe");
  a_strobe_after_ale: assert property (ale |=> !rd_n || !wr_n)
    else $error("no strobe after latch strobe");
  a_strobes_exclusive: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes both low");
  a_word_in_read: assert property (!read_word_strobe_n |-> !rd_n)
    else $error("word strobe outside a read");
  a_ack_in_cycle: assert property (!ack_n |-> !rd_n || !wr_n)
    else $error("acknowledge outside a cycle");
  a_ack_with_word: assert property (!ack_n && !rd_n |-> !read_word_strobe_n)
    else $error("read acknowledge without word strobe");
  a_ack_one_cycle: assert property (!ack_n |=> ack_n)
    else $error("acknowledge held too long");
  a_word_one_cycle: assert property (!read_word_strobe_n |=> read_word_strobe_n)
    else $error("word strobe held too long");
  a_read_ack_bound: assert property ($fell(rd_n) |-> ##[1:8] !ack_n)
    else $error("read not acknowledged in time");
endmodule : btq_link_monitor

`default_nettype wire

// ===== dv/bus_trace_capture_qualifier_tb.sv
// self-checking bench for both ends of the trace qualifier link
`timescale 1ns/1ps
`default_nettype none

module bus_trace_capture_qualifier_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic req_burst = 1'b0;
  logic [1:0] req_class = 2'h0;
  logic [31:0] req_addr = 32'h0;
  logic [31:0] req_data = 32'h0;
  logic req_ready, cap_valid, cap_load_data, cacheable_probe;
  logic instr_or_data_probe, last_load;
  logic [1:0] held_access_class;
  logic [31:0] cap_addr, cap_data, last_addr, last_data;
  btq_pkg::btq_kind_e cap_kind, last_kind;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_cap = 0;
  int wlow = 0;

  btq_if bus ();
  btq_cpu_end btq_cpu_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus(bus), .req_valid(req_valid), .req_write(req_write),
    .req_burst(req_burst), .req_class(req_class), .req_addr(req_addr),
    .req_data(req_data), .req_ready(req_ready));
  btq_qual_end btq_qual_end_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .bus(bus), .cap_valid(cap_valid), .cap_kind(cap_kind),
    .cap_addr(cap_addr), .cap_data(cap_data),
    .cap_load_data(cap_load_data), .cacheable_probe(cacheable_probe),
    .instr_or_data_probe(instr_or_data_probe),
    .held_access_class(held_access_class));
  btq_link_monitor btq_link_monitor_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .ale(bus.ale), .wr_n(bus.wr_n), .rd_n(bus.rd_n),
    .ack_n(bus.ack_n), .read_word_strobe_n(bus.read_word_strobe_n));

  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done

  task automatic xfer(input logic w, b, input logic [1:0] c,
                      input logic [31:0] a, d, input int n);
    int k;
    int base;
    base = n_cap;
    k = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_burst <= b;
    req_class <= c;
    req_addr <= a;
    req_data <= d;
    do begin
      @(posedge ref_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 60);
    req_valid <= 1'b0;
    while (n_cap - base < n && k < 60) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (8) @(posedge ref_clk);
    if (k >= 60) begin
      n_mismatch++;
      test_done();
    end
    chk("records", n, n_cap - base);
  endtask : xfer

  // capture of records and write gating watch
  always @(posedge ref_clk) begin
    if (cap_valid === 1'b1) begin
      n_cap++;
      last_kind = cap_kind;
      last_addr = cap_addr;
      last_data = cap_data;
      last_load = cap_load_data;
    end
    // probe lags the pin by three edges, so look as the write ends
    if (bus.wr_n === 1'b1 && wlow >= 3) chk("wr_probe", 0, cacheable_probe);
    wlow = (bus.wr_n === 1'b0) ? wlow + 1 : 0;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_class_reads();
    btq_pkg::btq_kind_e k;
    for (int c = 0; c < 4; c++) begin
      k = c[1] ? (c[0] ? btq_pkg::BTQ_KIND_INSTR : btq_pkg::BTQ_KIND_DATA)
               : btq_pkg::BTQ_KIND_NONE;
      xfer(1'b0, 1'b0, c[1:0], 32'h1fc0_0200 + c, 32'h8c49_0000 + c, 1);
      chk("held", c, held_access_class);
      chk("kind", k, last_kind);
      chk("addr", 32'h1fc0_0200 + c, last_addr);
      chk("data", 32'h8c49_0000 + c, last_data);
      chk("cache_probe", c[1], cacheable_probe);
      chk("instr_probe", c[0], instr_or_data_probe);
    end
  endtask : t_class_reads

  task automatic t_write();
    xfer(1'b1, 1'b0, 2'h3, 32'h0000_0004, 32'haaaa_5555, 1);
    chk("kind", btq_pkg::BTQ_KIND_WRITE, last_kind);
    chk("addr", 32'h0000_0004, last_addr);
    chk("data", 32'haaaa_5555, last_data);
  endtask : t_write

  task automatic t_burst();
    xfer(1'b0, 1'b1, 2'h3, 32'h1fc0_0300, 32'h2400_0001, 4);
    chk("kind", btq_pkg::BTQ_KIND_INSTR, last_kind);
    xfer(1'b0, 1'b1, 2'h2, 32'h0000_0020, 32'h0000_0001, 4);
    chk("kind", btq_pkg::BTQ_KIND_DATA, last_kind);
    xfer(1'b0, 1'b0, 2'h2, 32'h0000_0030, 32'h0000_0002, 1);
    chk("data", 32'h0000_0002, last_data);
  endtask : t_burst

  task automatic t_load_lag();
    xfer(1'b0, 1'b0, 2'h3, 32'h1fc0_0240, 32'h8d09_0000, 1);
    xfer(1'b0, 1'b0, 2'h2, 32'h0000_0010, 32'h1234_5678, 1);
    chk("load_flag", 0, last_load);
    xfer(1'b0, 1'b0, 2'h2, 32'h0000_0014, 32'h0bad_f00d, 1);
    chk("load_flag", 1, last_load);
  endtask : t_load_lag

  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    chk("held_rst", 0, held_access_class);
    chk("cache_rst", 0, cacheable_probe);
    t_class_reads();
    t_write();
    t_burst();
    t_write();
    t_load_lag();
    test_done();
  end
endmodule : bus_trace_capture_qualifier_tb

`default_nettype wire
